// file: inc/csa_pkg.sv
/*
  Shared constants for the CPU status and control block: register offsets,
  bit positions, reset values and divider timing.
  Assumes a 32-bit AXI4-Lite register bus with 16-bit registers in the low half.
*/
`default_nettype none
package csa_pkg;
  // Byte offsets on the register bus.
  localparam logic [7:0] CSA_OFS_FLAGS = 8'h00, CSA_OFS_CTRL = 8'h04, CSA_OFS_DVD_LO = 8'h08,
    CSA_OFS_DVD_HI = 8'h0c, CSA_OFS_DVS = 8'h10, CSA_OFS_DCMD = 8'h14, CSA_OFS_QUO = 8'h18,
    CSA_OFS_REM = 8'h1c;
  // Flag register bit positions.
  localparam int FB_GOV_A = 15, FB_GOV_B = 14, FB_CLIP_A = 13, FB_CLIP_B = 12,
    FB_GOV_ANY = 11, FB_CLIP_ANY = 10, FB_LOOP = 9, FB_HC = 8, FB_PRIO = 5, FB_REP = 4,
    FB_NEG = 3, FB_WRAP = 2, FB_ZERO = 1, FB_CARRY = 0;
  // Core control register bit positions.
  localparam int CB_UNS = 12, CB_EXIT = 11, CB_DEPTH = 8, CB_CLIP_A = 7, CB_CLIP_B = 6,
    CB_CLIP_ST = 5, CB_WIDTH = 4, CB_PMSB = 3, CB_PWIN = 2, CB_ROUND = 1, CB_INT = 0;
  // Divider command bits, ALU flag-mask bit for half carry.
  localparam int DB_GO = 0, DB_SIGNED = 1, DB_BUSY = 0, AM_HC = 4;
  localparam logic [15:0] CSA_FLAGS_RST = 16'h0000;
  localparam logic [15:0] CSA_CTRL_RST  = 16'h0000;
  localparam logic [1:0]  CSA_RESP_OKAY = 2'h0;
  localparam logic [1:0]  CSA_RESP_SLVERR = 2'h2;
  localparam int CSA_DIV_BITS = 16;
  localparam int CSA_DIV_CYC  = 19;
endpackage
`default_nettype wire

// file: rtl/csa_div.sv
/*
  Iterative signed/unsigned 32/16 divider, one cycle per divisor bit.
  Assumes operands stay meaningful only at the start pulse; hold freezes it.
*/
`default_nettype none
module csa_div
  import csa_pkg::*;
#(
  parameter int W = CSA_DIV_BITS
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           start,
  input  wire logic           hold,
  input  wire logic           sgn,
  input  wire logic [2*W-1:0] dividend,
  input  wire logic [W-1:0]   divisor,
  output logic                busy,
  output logic                done,
  output logic [W-1:0]        quotient_reg,
  output logic [W-1:0]        remainder_reg
);
  typedef enum logic [2:0] {DV_IDLE, DV_PREP, DV_ITER, DV_FIX, DV_DONE} csa_dv_e;
  csa_dv_e          st;
  logic [W-1:0]     rem;
  logic [W-1:0]     quo;
  logic [W-1:0]     dvs;
  logic             neg_q;
  logic             neg_r;
  logic             sgn_q;
  logic [7:0]       cnt;

  wire [2*W-1:0] raw     = {rem, quo};
  // Signedness is latched at the start pulse, so the bus may move on meanwhile.
  wire [2*W-1:0] raw_abs = (sgn_q && raw[2*W-1]) ? -raw : raw;
  wire [W-1:0]   dvs_abs = (sgn_q && dvs[W-1]) ? -dvs : dvs;
  wire [W:0]     shl     = {rem, quo[W-1]};
  wire [W+1:0]   diff    = {1'b0, shl} - {2'h0, dvs};
  wire           fits    = !diff[W+1];

  assign busy = (st != DV_IDLE);
  assign done = (st == DV_DONE);

  // Hold freezes every register outside DV_IDLE, so an interrupt costs time but no data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= DV_IDLE;
      rem <= '0;
      quo <= '0;
      dvs <= '0;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      sgn_q <= 1'b0;
      cnt <= 8'h00;
      quotient_reg <= '0;
      remainder_reg <= '0;
    end else if (!hold || st == DV_IDLE) begin
      case (st)
        DV_IDLE: if (start) begin
          {rem, quo} <= dividend;
          dvs <= divisor;
          sgn_q <= sgn;
          st <= DV_PREP;
        end
        DV_PREP: begin
          {rem, quo} <= raw_abs;
          dvs <= dvs_abs;
          neg_q <= sgn_q && (raw[2*W-1] ^ dvs[W-1]);
          neg_r <= sgn_q && raw[2*W-1];
          cnt <= 8'(W);
          st <= DV_ITER;
        end
        DV_ITER: begin
          rem <= fits ? diff[W-1:0] : shl[W-1:0];
          quo <= {quo[W-2:0], fits};
          cnt <= cnt - 8'h01;
          if (cnt == 8'h01) st <= DV_FIX;
        end
        DV_FIX: begin
          quotient_reg <= neg_q ? -quo : quo;
          remainder_reg <= neg_r ? -rem : rem;
          st <= DV_DONE;
        end
        DV_DONE: st <= DV_IDLE;
        default: st <= DV_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0]     run_cnt;
  logic [2*W-1:0] op_dvd;
  logic [W-1:0]   op_dvs;
  logic           op_sgn;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_cnt <= 8'h00;
      op_dvd <= '0;
      op_dvs <= '0;
      op_sgn <= 1'b0;
    end else if (start && !busy) begin
      run_cnt <= 8'h01;
      op_dvd <= dividend;
      op_dvs <= divisor;
      op_sgn <= sgn;
    end else if (busy && !hold) begin
      run_cnt <= run_cnt + 8'h01;
    end
  end
  sequence s_go;
    start && !busy;
  endsequence
  sequence s_free_run;
    (busy && !done && !hold) [*8];
  endsequence
  a_div_length: assert property (done |-> run_cnt == 8'(CSA_DIV_CYC))
    else $error("divide did not take the set number of cycles");
  a_div_steps: assert property (s_go ##1 s_free_run |=> busy)
    else $error("divide ended too early");
  a_div_result: assert property (done && !op_sgn && op_dvs != '0 &&
      op_dvd[2*W-1:W] < op_dvs |->
      (2*W)'(quotient_reg) * (2*W)'(op_dvs) + (2*W)'(remainder_reg) == op_dvd)
    else $error("quotient and remainder do not rebuild the dividend");
endmodule
`default_nettype wire

// file: rtl/csa_top.sv
/*
  CPU status/control block: ALU condition flags, accumulator overflow and
  saturation status, loop status, priority level, DSP mode control, and the
  divide unit, all reached over AXI4-Lite.
  Assumes every status input comes from core logic on aclk.
*/
// Summary of operation
// - Accumulator A and B guard overflow flags at bits 15 and 14, read-only.
// - Sticky saturation flags at bits 13 and 12; software may only clear them.
// - Bit 11 reads as OR of both guard overflow flags.
// - Bit 10 is OR of saturation flags; clearing it clears both.
// - Bit 9 is high while a hardware loop is running.
// - Bit 8 half carry from bit 3 (byte) or bit 7 (word).
// - Priority is bits 7-5 plus control bit 3; top bit only clearable.
// - Low priority bits are read-only while nesting is disabled.
// - Bit 4 is high while a single-instruction repeat runs.
// - Bit 3 set on negative result, cleared otherwise.
// - Bit 2 set on two's-complement overflow changing the sign.
// - Bit 1 zero flag, set on zero result, cleared otherwise.
// - Bit 0 carry out of MSB; carry and half carry borrow on subtract.
// - Control bit 12 selects unsigned multiply; bits 15-13 read zero.
// - Writing 1 to control bit 11 ends the loop; reads zero.
// - Control bits 10-8 show active loop nesting depth, read-only.
// - Control bits 7, 6, 5 enable saturation for A, B, stores.
// - Control bit 4 picks 9.31 over 1.31 saturation.
// - Control bit 2 makes program space visible in data space.
// - Control bit 1 picks biased rounding over convergent rounding.
// - Control bit 0 picks integer over fractional multiply.
// - Quotient goes to the quotient register, remainder to the remainder register.
// - A divide takes 19 cycles and may pause at any cycle.
`default_nettype none
module csa_top
  import csa_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              acc_a_upd,
  input  wire logic              acc_a_ovf,
  input  wire logic              acc_a_sat_evt,
  input  wire logic              acc_b_upd,
  input  wire logic              acc_b_ovf,
  input  wire logic              acc_b_sat_evt,
  input  wire logic              alu_upd,
  input  wire logic [4:0]        alu_mask,
  input  wire logic              alu_byte,
  input  wire logic              alu_sub,
  input  wire logic [15:0]       alu_a,
  input  wire logic [15:0]       alu_b,
  input  wire logic              hw_loop_active,
  input  wire logic              repeat_loop_busy,
  input  wire logic [2:0]        loop_nest_depth,
  input  wire logic              nesting_off_flag,
  input  wire logic              prio_wr,
  input  wire logic [3:0]        prio_val,
  input  wire logic              div_hold,
  output logic [3:0]             cpu_prio,
  output logic                   user_int_off,
  output logic                   loop_early_exit,
  output logic                   unsigned_mul_sel,
  output logic                   acc_a_clip_en,
  output logic                   acc_b_clip_en,
  output logic                   store_clip_en,
  output logic                   clip_width_sel,
  output logic                   prog_window_en,
  output logic                   round_mode_sel,
  output logic                   mul_int_mode,
  output logic                   div_busy,
  output logic                   div_done,
  output logic [15:0]            quotient_reg,
  output logic [15:0]            remainder_reg
);
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a[1:0] == 2'h0 && a <= ADDR_W'(CSA_OFS_REM);
  endfunction
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Flag and control state.
  logic        oa, ob, sa, sb, hc, neg, wrap, zero, carry;
  logic [2:0]  prio_lo;
  logic        prio_msb;
  logic [15:0] dvd_lo, dvd_hi, dvs;
  logic        div_sgn;

  wire [15:0] flags_rd = {oa, ob, sa, sb, oa | ob, sa | sb, hw_loop_active, hc,
                          prio_lo, repeat_loop_busy, neg, wrap, zero, carry};
  wire [15:0] ctrl_rd = {3'h0, unsigned_mul_sel, 1'b0, loop_nest_depth, acc_a_clip_en,
                         acc_b_clip_en, store_clip_en, clip_width_sel, prio_msb,
                         prog_window_en, round_mode_sel, mul_int_mode};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave. Address and data may arrive in either order.
  logic              aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire wr_go   = (aw_held || aw_fire) && (w_held || w_fire);
  wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0]       wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]        wr_strb = w_held ? w_strb : s_axi_wstrb;

  wire wr_flags = wr_go && wr_addr == ADDR_W'(CSA_OFS_FLAGS);
  wire wr_ctrl  = wr_go && wr_addr == ADDR_W'(CSA_OFS_CTRL);
  wire wr_dcmd  = wr_go && wr_addr == ADDR_W'(CSA_OFS_DCMD);
  wire [15:0] wf = merge(flags_rd, wr_data, wr_strb);
  wire [15:0] wc = merge(ctrl_rd, wr_data, wr_strb);
  wire [15:0] wd = merge(16'h0000, wr_data, wr_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CSA_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_addr) ? CSA_RESP_OKAY : CSA_RESP_SLVERR;
      end else begin
        if (aw_fire) aw_held <= 1'b1;
        if (w_fire) w_held <= 1'b1;
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
      if (aw_fire) aw_addr <= s_axi_awaddr;
      if (w_fire) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  logic [15:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      ADDR_W'(CSA_OFS_FLAGS):  rd_mux = flags_rd;
      ADDR_W'(CSA_OFS_CTRL):   rd_mux = ctrl_rd;
      ADDR_W'(CSA_OFS_DVD_LO): rd_mux = dvd_lo;
      ADDR_W'(CSA_OFS_DVD_HI): rd_mux = dvd_hi;
      ADDR_W'(CSA_OFS_DVS):    rd_mux = dvs;
      ADDR_W'(CSA_OFS_DCMD):   rd_mux = {14'h0000, div_sgn, div_busy};
      ADDR_W'(CSA_OFS_QUO):    rd_mux = quotient_reg;
      ADDR_W'(CSA_OFS_REM):    rd_mux = remainder_reg;
      default:                 rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CSA_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_mux};
      s_axi_rresp <= is_mapped(s_axi_araddr) ? CSA_RESP_OKAY : CSA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ALU flag calculation. Subtract adds the complement with carry in high,
  // so carry and half carry come out as active-low borrows.
  wire [15:0] b_eff = alu_sub ? ~alu_b : alu_b;
  wire [16:0] sum   = {1'b0, alu_a} + {1'b0, b_eff} + {16'h0000, alu_sub};
  wire [4:0]  nib   = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_sub};
  wire [8:0]  lob   = {1'b0, alu_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, alu_sub};
  wire a_msb  = alu_byte ? alu_a[7] : alu_a[15];
  wire b_msb  = alu_byte ? b_eff[7] : b_eff[15];
  wire r_msb  = alu_byte ? sum[7] : sum[15];
  wire c_hc   = alu_byte ? nib[4] : lob[8];
  wire c_cy   = alu_byte ? lob[8] : sum[16];
  wire c_wrap = (a_msb == b_msb) && (r_msb != a_msb);
  wire c_zero = alu_byte ? (sum[7:0] == 8'h00) : (sum[15:0] == 16'h0000);

  // Hardware updates win over a software write in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {hc, neg, wrap, zero, carry} <= 5'h00;
    end else begin
      if (alu_upd && alu_mask[AM_HC]) hc <= c_hc;
      else if (wr_flags) hc <= wf[FB_HC];
      if (alu_upd && alu_mask[FB_NEG]) neg <= r_msb;
      else if (wr_flags) neg <= wf[FB_NEG];
      if (alu_upd && alu_mask[FB_WRAP]) wrap <= c_wrap;
      else if (wr_flags) wrap <= wf[FB_WRAP];
      if (alu_upd && alu_mask[FB_ZERO]) zero <= c_zero;
      else if (wr_flags) zero <= wf[FB_ZERO];
      if (alu_upd && alu_mask[FB_CARRY]) carry <= c_cy;
      else if (wr_flags) carry <= wf[FB_CARRY];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator status. In 1.31 mode the guard bits are unused, so the
  // overflow flags stay low there.
  wire clr_sa = wr_flags && (!wf[FB_CLIP_A] || !wf[FB_CLIP_ANY]);
  wire clr_sb = wr_flags && (!wf[FB_CLIP_B] || !wf[FB_CLIP_ANY]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {oa, ob, sa, sb} <= 4'h0;
    end else begin
      if (acc_a_upd) oa <= acc_a_ovf && clip_width_sel;
      if (acc_b_upd) ob <= acc_b_ovf && clip_width_sel;
      if (acc_a_sat_evt) sa <= 1'b1;
      else if (clr_sa) sa <= 1'b0;
      if (acc_b_sat_evt) sb <= 1'b1;
      else if (clr_sb) sb <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority level and core control.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_lo <= CSA_FLAGS_RST[FB_PRIO +: 3];
      prio_msb <= CSA_CTRL_RST[CB_PMSB];
      {unsigned_mul_sel, acc_a_clip_en, acc_b_clip_en, store_clip_en} <= 4'h0;
      {clip_width_sel, prog_window_en, round_mode_sel, mul_int_mode} <= 4'h0;
      loop_early_exit <= 1'b0;
    end else begin
      if (prio_wr) prio_lo <= prio_val[2:0];
      else if (wr_flags && !nesting_off_flag) prio_lo <= wf[FB_PRIO +: 3];
      if (prio_wr) prio_msb <= prio_val[3];
      else if (wr_ctrl && !wc[CB_PMSB]) prio_msb <= 1'b0;
      loop_early_exit <= wr_ctrl && wc[CB_EXIT];
      if (wr_ctrl) begin
        unsigned_mul_sel <= wc[CB_UNS];
        acc_a_clip_en <= wc[CB_CLIP_A];
        acc_b_clip_en <= wc[CB_CLIP_B];
        store_clip_en <= wc[CB_CLIP_ST];
        clip_width_sel <= wc[CB_WIDTH];
        prog_window_en <= wc[CB_PWIN];
        round_mode_sel <= wc[CB_ROUND];
        mul_int_mode <= wc[CB_INT];
      end
    end
  end
  assign cpu_prio = {prio_msb, prio_lo};
  assign user_int_off = prio_msb;

  ////////////////////////////////////////////////////////////////////////////
  // Divide unit and its operand registers.
  wire div_start = wr_dcmd && wd[DB_GO] && !div_busy;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dvd_lo <= 16'h0000;
      dvd_hi <= 16'h0000;
      dvs <= 16'h0000;
      div_sgn <= 1'b0;
    end else begin
      if (wr_go && wr_addr == ADDR_W'(CSA_OFS_DVD_LO)) dvd_lo <= merge(dvd_lo, wr_data, wr_strb);
      if (wr_go && wr_addr == ADDR_W'(CSA_OFS_DVD_HI)) dvd_hi <= merge(dvd_hi, wr_data, wr_strb);
      if (wr_go && wr_addr == ADDR_W'(CSA_OFS_DVS)) dvs <= merge(dvs, wr_data, wr_strb);
      if (wr_dcmd) div_sgn <= wd[DB_SIGNED];
    end
  end

  csa_div #(
    .W (CSA_DIV_BITS)
  ) u_div (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .start         (div_start),
    .hold          (div_hold),
    .sgn           (wd[DB_SIGNED]),
    .dividend      ({dvd_hi, dvd_lo}),
    .divisor       (dvs),
    .busy          (div_busy),
    .done          (div_done),
    .quotient_reg  (quotient_reg),
    .remainder_reg (remainder_reg)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire rd_flags = ar_fire && s_axi_araddr == ADDR_W'(CSA_OFS_FLAGS);
  wire rd_ctrl  = ar_fire && s_axi_araddr == ADDR_W'(CSA_OFS_CTRL);

  a_guard_ovf_a: assert property (acc_a_upd |=> oa == $past(acc_a_ovf && clip_width_sel))
    else $error("accumulator A overflow flag wrong");
  a_clip_sticky: assert property (sa && !wr_flags |=> sa)
    else $error("saturation flag dropped without a clear");
  a_any_ovf_read: assert property (rd_flags |=> s_axi_rdata[FB_GOV_ANY] ==
      ($past(oa) || $past(ob)))
    else $error("combined overflow bit misread");
  a_any_clip_clear: assert property (wr_flags && !wf[FB_CLIP_ANY] &&
      !acc_a_sat_evt && !acc_b_sat_evt |=> !sa && !sb)
    else $error("combined clear left a saturation flag set");
  a_loop_status: assert property (rd_flags |=> s_axi_rdata[FB_LOOP] ==
      $past(hw_loop_active) && s_axi_rdata[FB_REP] == $past(repeat_loop_busy))
    else $error("loop status misread");
  a_half_carry: assert property (alu_upd && alu_mask[AM_HC] |=> hc == $past(c_hc))
    else $error("half carry not taken from the ALU");
  a_prio_msb_set: assert property (!prio_wr |=> !$rose(prio_msb))
    else $error("priority top bit set by software");
  a_prio_locked: assert property (nesting_off_flag && !prio_wr |=> $stable(prio_lo))
    else $error("priority bits changed while nesting is off");
  a_zero_flag: assert property (alu_upd && alu_mask[FB_ZERO] |=> zero == $past(c_zero))
    else $error("zero flag disagrees with result");
  a_exit_pulse: assert property (wr_ctrl && wc[CB_EXIT] |=> loop_early_exit ##1
      !loop_early_exit)
    else $error("loop exit is not a single pulse");
  a_ctrl_unimpl: assert property (rd_ctrl |=> s_axi_rdata[15:13] == 3'h0 &&
      !s_axi_rdata[CB_EXIT])
    else $error("unimplemented control bits read nonzero");
endmodule
`default_nettype wire

// file: tb/cpu_status_control_alu_tb_top.sv
/* Self-checking bench for csa_top: AXI4-Lite accesses, status inputs and
   divider, compared with a bench model. Assumes csa_pkg is compiled first. */
`default_nettype none
module cpu_status_control_alu_tb_top
  import csa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, acc_a_upd;
  logic acc_a_ovf, acc_a_sat_evt, acc_b_upd, acc_b_ovf, acc_b_sat_evt, alu_upd, alu_byte;
  logic alu_sub, hw_loop_active, repeat_loop_busy, nesting_off_flag, prio_wr, div_hold;
  logic user_int_off, loop_early_exit, unsigned_mul_sel, acc_a_clip_en, acc_b_clip_en;
  logic store_clip_en, clip_width_sel, prog_window_en, round_mode_sel, mul_int_mode;
  logic div_busy, div_done;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mo;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, lf;
  logic [3:0] s_axi_wstrb, prio_val, cpu_prio;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [4:0] alu_mask;
  logic [2:0] loop_nest_depth;
  logic [15:0] alu_a, alu_b, quotient_reg, remainder_reg, fm, ta, tb;
  int bad_count, checked, n, k, sd, sv;
  int bp[8] = '{12, 7, 6, 5, 4, 2, 1, 0};
  assign mo = {unsigned_mul_sel, acc_a_clip_en, acc_b_clip_en, store_clip_en, clip_width_sel,
               prog_window_en, round_mode_sel, mul_int_mode};
  csa_top DUT (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Sticky and stored bits come from fm; live status bits come from the inputs.
  function automatic logic [15:0] xf();
    return {fm[15:12], fm[15] | fm[14], fm[13] | fm[12], hw_loop_active, fm[8:5],
            repeat_loop_busy, fm[3:0]};
  endfunction
  task automatic report_and_stop;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic lim();
    if (n >= 60) begin
      bad_count++;
      report_and_stop;
    end
  endtask
  // Each access waits one edge first so a handshake signal is never lowered and raised at once.
  task automatic wt(input logic [7:0] a, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 60 && !(s_axi_bready && s_axi_bvalid); n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    rr = s_axi_bresp;
    lim();
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 60 && !(s_axi_rready && s_axi_rvalid); n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    lim();
    chk(rd, {16'h0000, e});
  endtask
  task automatic alu_m(input logic [4:0] m, input logic by, input logic sb);
    logic [15:0] bb;
    logic [16:0] s;
    logic [8:0] t;
    logic [4:0] q;
    int h;
    bb = sb ? ~tb : tb;
    s = {1'b0, ta} + {1'b0, bb} + 17'(sb);
    t = {1'b0, ta[7:0]} + {1'b0, bb[7:0]} + 9'(sb);
    q = {1'b0, ta[3:0]} + {1'b0, bb[3:0]} + 5'(sb);
    h = by ? 7 : 15;
    if (m[0]) fm[0] = by ? t[8] : s[16];
    if (m[1]) fm[1] = by ? (s[7:0] == 8'h00) : (s[15:0] == 16'h0000);
    if (m[2]) fm[2] = (ta[h] == bb[h]) && (s[h] != ta[h]);
    if (m[3]) fm[3] = s[h];
    if (m[4]) fm[8] = by ? q[4] : t[8];
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     acc_a_upd, acc_a_ovf, acc_a_sat_evt, acc_b_upd, acc_b_ovf, acc_b_sat_evt, alu_upd,
     alu_byte, alu_sub, hw_loop_active, repeat_loop_busy, nesting_off_flag, prio_wr,
     div_hold, s_axi_awaddr, s_axi_araddr, s_axi_wdata, prio_val, alu_mask,
     loop_nest_depth, alu_a, alu_b, fm} = '0;
    s_axi_wstrb = 4'hf;
    bad_count = 0;
    checked = 0;
    lf = 32'd94532;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(CSA_OFS_FLAGS, CSA_FLAGS_RST);
    rc(CSA_OFS_CTRL, CSA_CTRL_RST);
    loop_nest_depth <= 3'h5;
    hw_loop_active <= 1'b1;
    repeat_loop_busy <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wt(CSA_OFS_CTRL, 16'h1 << bp[i]);
      chk(mo, 32'h80 >> i);
      rc(CSA_OFS_CTRL, (16'h1 << bp[i]) | 16'h0500);
    end
    wt(CSA_OFS_CTRL, 16'hffff);
    chk(loop_early_exit, 1'b1);
    @(posedge aclk);
    chk(loop_early_exit, 1'b0);
    rc(CSA_OFS_CTRL, 16'h15f7);
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      ta = lf[15:0];
      tb = (i == 0) ? ta : lf[31:16];
      lf = lfsr(lf);
      alu_a <= ta;
      alu_b <= tb;
      alu_mask <= (i < 4) ? 5'h1f : lf[8:4];
      alu_byte <= lf[2];
      alu_sub <= lf[1] | (i == 0);
      alu_upd <= 1'b1;
      @(posedge aclk);
      alu_upd <= 1'b0;
      alu_m(alu_mask, alu_byte, alu_sub);
      rc(CSA_OFS_FLAGS, xf());
    end
    {acc_a_upd, acc_a_ovf, acc_a_sat_evt, acc_b_sat_evt} <= 4'hf;
    @(posedge aclk);
    {acc_a_upd, acc_a_ovf, acc_a_sat_evt, acc_b_sat_evt} <= 4'h0;
    fm[15:12] = 4'hb;
    rc(CSA_OFS_FLAGS, xf());
    {acc_a_upd, acc_b_upd, acc_b_ovf} <= 3'h7;
    @(posedge aclk);
    {acc_a_upd, acc_b_upd, acc_b_ovf} <= 3'h0;
    fm[15:14] = 2'b01;
    rc(CSA_OFS_FLAGS, xf());
    wt(CSA_OFS_FLAGS, 16'hfbff);
    fm = (fm & 16'hc000) | 16'h01ef;
    rc(CSA_OFS_FLAGS, xf());
    nesting_off_flag <= 1'b1;
    hw_loop_active <= 1'b0;
    repeat_loop_busy <= 1'b0;
    wt(CSA_OFS_FLAGS, 16'h0000);
    fm = fm & 16'hc0e0;
    rc(CSA_OFS_FLAGS, xf());
    prio_wr <= 1'b1;
    prio_val <= 4'ha;
    @(posedge aclk);
    prio_wr <= 1'b0;
    @(posedge aclk);
    fm[7:5] = 3'h2;
    chk({user_int_off, cpu_prio}, 5'h1a);
    wt(CSA_OFS_CTRL, 16'h0010);
    chk({user_int_off, cpu_prio}, 5'h02);
    rc(CSA_OFS_FLAGS, xf());
    for (int s = 0; s < 2; s++) begin
      lf = lfsr(lf);
      ta = lf[15:0];
      sd = s ? int'($signed(ta)) : int'({1'b0, lf[30:16], ta});
      lf = lfsr(lf);
      tb = s ? {1'b0, lf[14:1], 1'b1} : (lf[15:0] | 16'h8000);
      sv = int'(tb);
      wt(CSA_OFS_DVD_LO, ta);
      wt(CSA_OFS_DVD_HI, 16'(sd >>> 16));
      wt(CSA_OFS_DVS, tb);
      wt(CSA_OFS_DCMD, {14'h0000, s[0], 1'b1});
      chk(div_busy, 1'b1);
      for (k = 1; k < 80 && div_done !== 1'b1; k++) begin
        div_hold <= (s == 1 && k >= 2 && k < 5);
        @(posedge aclk);
      end
      chk(k, 19 + 3 * s);
      if (k >= 80) report_and_stop;
      chk({quotient_reg, remainder_reg}, {16'(sd / sv), 16'(sd % sv)});
      rc(CSA_OFS_QUO, 16'(sd / sv));
      rc(CSA_OFS_REM, 16'(sd % sv));
      rc(CSA_OFS_DCMD, {14'h0000, s[0], 1'b0});
    end
    rc(8'h20, 16'h0000);
    chk(rr, CSA_RESP_SLVERR);
    wt(8'h02, 16'hffff);
    chk(rr, CSA_RESP_SLVERR);
    s_axi_wstrb <= 4'h2;
    wt(CSA_OFS_CTRL, 16'h10ff);
    s_axi_wstrb <= 4'hf;
    chk(mo, 32'h88);
    rc(CSA_OFS_FLAGS, xf());
    report_and_stop;
  end
endmodule
`default_nettype wire
